// ==== coc_regs.sv ====
// Summary of operation
// RQ1: The bank answers bus transfers at write address d2 and read address d3 only.
// RQ2: Bit 6 of byte 1 is a read-write enable for output pair 0 that resets to 1.
// RQ3: Bit 3 of byte 1 is a read-write enable for output pair 1 that resets to 1.
// RQ4: Bit 7 of byte 3 is a read-write enable for output pair 5 that resets to 1.
// RQ5: Bit 6 of byte 3 is a read-write enable for output pair 4 that resets to 1.
// RQ6: Bit 6 of byte 9 is a read-write enable for output pair 3 that resets to 1.
// RQ7: Bit 5 of byte 9 is a read-write enable for output pair 2 that resets to 1.
// RQ8: Each two-bit swing code picks 700, 800, 900 or 1000 mV for codes 00 to 11.
// RQ9: Byte 5 holds the upper group swing in bits 7:6, middle in 5:4 and first in 1:0.
// RQ10: Byte 7 is read-only with a fixed revision code high and maker code low.
// RQ11: Bytes 2, 4 and 6 are reserved, read zero and do nothing.
// RQ12: A write carries index, count and data bytes, each acknowledged and stored in turn.
// RQ13: A read after index and repeated start returns a count then data, host acks each.
// RQ14: A disabled pair drives both of its legs low instead of toggling.
// RQ15: The host writes reserved bits with their defaults and does not expect them to stick; the testbench host writes random or fixed values into them.
`timescale 1ns/1ps
module coc_regs #(
  parameter logic [3:0] REVISION_CODE = 4'h5,  // arbitrary value
  parameter logic [3:0] MAKER_CODE    = 4'ha   // arbitrary value
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // bus pins
  input  wire logic       smb_clk_i,
  input  wire logic       smb_dat_i,
  output logic            smb_dat_o,
  output logic            smb_dat_oe_n_o,
  // synthesized clocks in, pairs out
  input  wire logic [5:0] pair_clk_i,
  output logic      [5:0] pair_true_o,
  output logic      [5:0] pair_comp_o,
  // control fields
  output logic      [5:0] out_on_o,
  output logic      [1:0] upper_group_swing_o,
  output logic      [1:0] middle_group_swing_o,
  output logic      [1:0] first_output_swing_o
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_CNT, ST_CNT_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_TX, ST_TX_ACK, ST_SKIP
  } coc_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  coc_pkg::coc_smb_ev_type ev;
  coc_state_type state_ff, nxt_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] idx_ff, nxt_idx;
  logic [7:0] cnt_ff, nxt_cnt;
  logic       oe_n_ff, nxt_oe_n;
  logic       wr_en;
  logic [7:0] oe_low_ff, oe_high_ff, amp_ff, oe_mid_ff;
  logic [5:0] out_on_ff;
  logic [5:0] true_ff, comp_ff;

  coc_smb_edge u_edge (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .smb_clk_i  (smb_clk_i),
    .smb_dat_i  (smb_dat_i),
    .ev_o       (ev)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // byte decode

  // merges writable bits only; reserved bits keep their value
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  // registers come in as arguments so the wire below follows every one of them
  function automatic logic [7:0] rd_byte(input logic [7:0] idx, input logic [7:0] lo,
                                         input logic [7:0] hi, input logic [7:0] amp,
                                         input logic [7:0] mid);
    case (idx)
      coc_pkg::IDX_OE_LOW:    rd_byte = lo;
      coc_pkg::IDX_OE_HIGH:   rd_byte = hi;
      coc_pkg::IDX_AMP:       rd_byte = amp;
      coc_pkg::IDX_ID:        rd_byte = {REVISION_CODE, MAKER_CODE};  // [RQ10]
      coc_pkg::IDX_RSVD_8:    rd_byte = coc_pkg::RSVD_8_VAL;
      coc_pkg::IDX_RSVD_TWO,
      coc_pkg::IDX_RSVD_FOUR,
      coc_pkg::IDX_RSVD_SIX:  rd_byte = coc_pkg::RSVD_ZERO;  // [RQ11]
      coc_pkg::IDX_OE_MID:    rd_byte = mid;
      default:                rd_byte = coc_pkg::RSVD_ZERO;
    endcase
  endfunction

  wire [7:0] cur_byte   = rd_byte(idx_ff, oe_low_ff, oe_high_ff, amp_ff, oe_mid_ff);
  wire       byte_done  = ev.scl_fall && (bit_cnt_ff == coc_pkg::BITS_BYTE);
  wire       addr_match = (shift_ff[7:1] == coc_pkg::WR_ADDR[7:1]);  // [RQ1]
  wire       cnt_left   = (cnt_ff != 8'h00);

  ////////////////////////////////////////////////////////////////////////////////
  // protocol

  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift   = shift_ff;
    nxt_idx     = idx_ff;
    nxt_cnt     = cnt_ff;
    nxt_oe_n    = oe_n_ff;
    wr_en       = 1'b0;
    if (ev.start) begin
      nxt_state   = ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_oe_n    = 1'b1;
    end else if (ev.stop) begin
      nxt_state   = ST_IDLE;
      nxt_oe_n    = 1'b1;
    end else begin
      case (state_ff)
        ST_ADDR, ST_CMD, ST_CNT, ST_WDATA: begin
          if (ev.scl_rise && bit_cnt_ff < coc_pkg::BITS_BYTE) begin
            nxt_shift   = {shift_ff[6:0], ev.sda};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
          if (byte_done) begin
            nxt_oe_n = 1'b0;
            case (state_ff)
              ST_ADDR: begin
                if (addr_match) begin
                  nxt_state = ST_ADDR_ACK;  // [RQ1]
                end else begin
                  nxt_state = ST_SKIP;
                  nxt_oe_n  = 1'b1;
                end
              end
              ST_CMD: begin
                nxt_idx   = shift_ff;  // [RQ12]
                nxt_state = ST_CMD_ACK;
              end
              ST_CNT: begin
                nxt_cnt   = shift_ff;  // [RQ12]
                nxt_state = ST_CNT_ACK;
              end
              default: begin
                // data beyond the count is acked but dropped
                wr_en     = cnt_left;  // [RQ12]
                nxt_idx   = cnt_left ? idx_ff + 8'h01 : idx_ff;
                nxt_cnt   = cnt_left ? cnt_ff - 8'h01 : cnt_ff;
                nxt_state = ST_WDATA_ACK;
              end
            endcase
          end
        end
        ST_ADDR_ACK: begin
          if (ev.scl_fall) begin
            nxt_bit_cnt = 4'h0;
            nxt_oe_n    = 1'b1;
            nxt_state   = ST_CMD;
            if (shift_ff[0]) begin
              // count byte goes first, then data from the index
              nxt_shift   = coc_pkg::RSVD_8_VAL;  // [RQ13]
              nxt_oe_n    = coc_pkg::RSVD_8_VAL[7];
              nxt_bit_cnt = 4'h1;
              nxt_state   = ST_TX;
            end
          end
        end
        ST_CMD_ACK, ST_CNT_ACK, ST_WDATA_ACK: begin
          if (ev.scl_fall) begin
            nxt_bit_cnt = 4'h0;
            nxt_oe_n    = 1'b1;
            nxt_state   = (state_ff == ST_CMD_ACK) ? ST_CNT : ST_WDATA;
          end
        end
        ST_TX: begin
          if (ev.scl_fall) begin
            if (bit_cnt_ff == coc_pkg::BITS_BYTE) begin
              nxt_oe_n  = 1'b1;
              nxt_state = ST_TX_ACK;
            end else begin
              nxt_shift   = {shift_ff[6:0], 1'b0};
              nxt_oe_n    = shift_ff[6];
              nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (ev.scl_rise) begin
            // a not-acknowledge ends the read
            nxt_state   = ev.sda ? ST_SKIP : ST_TX_ACK;  // [RQ13]
            nxt_bit_cnt = coc_pkg::BITS_ACKED;
          end else if (ev.scl_fall && bit_cnt_ff == coc_pkg::BITS_ACKED) begin
            nxt_shift   = cur_byte;  // [RQ13]
            nxt_oe_n    = cur_byte[7];
            nxt_idx     = idx_ff + 8'h01;
            nxt_bit_cnt = 4'h1;
            nxt_state   = ST_TX;
          end
        end
        ST_SKIP, ST_IDLE: begin
          nxt_oe_n = 1'b1;
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_oe_n  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      idx_ff     <= 8'h00;
      cnt_ff     <= 8'h00;
      oe_n_ff    <= 1'b1;
    end else if (ce_i) begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff   <= nxt_shift;
      idx_ff     <= nxt_idx;
      cnt_ff     <= nxt_cnt;
      oe_n_ff    <= nxt_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register bank

  wire wr_oe_low  = wr_en && idx_ff == coc_pkg::IDX_OE_LOW;
  wire wr_oe_high = wr_en && idx_ff == coc_pkg::IDX_OE_HIGH;
  wire wr_amp     = wr_en && idx_ff == coc_pkg::IDX_AMP;
  wire wr_oe_mid  = wr_en && idx_ff == coc_pkg::IDX_OE_MID;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_low_ff  <= coc_pkg::RST_OE_LOW;   // [RQ2] [RQ3]
      oe_high_ff <= coc_pkg::RST_OE_HIGH;  // [RQ4] [RQ5]
      amp_ff     <= coc_pkg::RST_AMP;
      oe_mid_ff  <= coc_pkg::RST_OE_MID;   // [RQ6] [RQ7]
    end else if (ce_i) begin
      if (wr_oe_low)  oe_low_ff  <= merge(oe_low_ff, shift_ff, coc_pkg::MSK_OE_LOW);
      if (wr_oe_high) oe_high_ff <= merge(oe_high_ff, shift_ff, coc_pkg::MSK_OE_HIGH);
      if (wr_amp)     amp_ff     <= merge(amp_ff, shift_ff, coc_pkg::MSK_AMP);  // [RQ9]
      if (wr_oe_mid)  oe_mid_ff  <= merge(oe_mid_ff, shift_ff, coc_pkg::MSK_OE_MID);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output pairs

  wire [5:0] nxt_out_on = {oe_high_ff[coc_pkg::POS_OUT5_ON],   // [RQ4]
                           oe_high_ff[coc_pkg::POS_OUT4_ON],   // [RQ5]
                           oe_mid_ff[coc_pkg::POS_OUT3_ON],    // [RQ6]
                           oe_mid_ff[coc_pkg::POS_OUT2_ON],    // [RQ7]
                           oe_low_ff[coc_pkg::POS_OUT1_ON],    // [RQ3]
                           oe_low_ff[coc_pkg::POS_OUT0_ON]};   // [RQ2]

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_on_ff <= 6'h00;
      true_ff   <= 6'h00;
      comp_ff   <= 6'h00;
    end else if (ce_i) begin
      out_on_ff <= nxt_out_on;
      true_ff   <= nxt_out_on & pair_clk_i;   // [RQ14]
      comp_ff   <= nxt_out_on & ~pair_clk_i;  // [RQ14]
    end
  end

  assign smb_dat_o            = 1'b0;
  assign smb_dat_oe_n_o       = oe_n_ff;
  assign pair_true_o          = true_ff;
  assign pair_comp_o          = comp_ff;
  assign out_on_o             = out_on_ff;
  // swing code to driver: 00 700 mV up to 11 1000 mV
  assign upper_group_swing_o  = amp_ff[coc_pkg::POS_UPPER_SWING +: 2];   // [RQ8] [RQ9]
  assign middle_group_swing_o = amp_ff[coc_pkg::POS_MIDDLE_SWING +: 2];  // [RQ8] [RQ9]
  assign first_output_swing_o = amp_ff[coc_pkg::POS_FIRST_SWING +: 2];   // [RQ8] [RQ9]

endmodule

// ==== coc_pkg.sv ====
package coc_pkg;

  // bus addresses, 8-bit form with the direction bit
  localparam logic [7:0] WR_ADDR       = 8'hd2;
  localparam logic [7:0] RD_ADDR       = 8'hd3;

  // byte indices
  localparam logic [7:0] IDX_OE_LOW    = 8'h01;
  localparam logic [7:0] IDX_RSVD_TWO  = 8'h02;
  localparam logic [7:0] IDX_OE_HIGH   = 8'h03;
  localparam logic [7:0] IDX_RSVD_FOUR = 8'h04;
  localparam logic [7:0] IDX_AMP       = 8'h05;
  localparam logic [7:0] IDX_RSVD_SIX  = 8'h06;
  localparam logic [7:0] IDX_ID        = 8'h07;
  localparam logic [7:0] IDX_RSVD_8    = 8'h08;
  localparam logic [7:0] IDX_OE_MID    = 8'h09;

  // reset values and writable-bit masks
  localparam logic [7:0] RST_OE_LOW    = 8'h48;
  localparam logic [7:0] MSK_OE_LOW    = 8'h48;
  localparam logic [7:0] RST_OE_HIGH   = 8'hc0;
  localparam logic [7:0] MSK_OE_HIGH   = 8'hc0;
  localparam logic [7:0] RST_AMP       = 8'h51;
  localparam logic [7:0] MSK_AMP       = 8'hf3;
  localparam logic [7:0] RST_OE_MID    = 8'h60;
  localparam logic [7:0] MSK_OE_MID    = 8'h60;
  localparam logic [7:0] RSVD_ZERO     = 8'h00;
  localparam logic [7:0] RSVD_8_VAL    = 8'h0f;

  // field positions
  localparam int POS_OUT0_ON           = 6;
  localparam int POS_OUT1_ON           = 3;
  localparam int POS_OUT5_ON           = 7;
  localparam int POS_OUT4_ON           = 6;
  localparam int POS_OUT3_ON           = 6;
  localparam int POS_OUT2_ON           = 5;
  localparam int POS_UPPER_SWING       = 6;
  localparam int POS_MIDDLE_SWING      = 4;
  localparam int POS_FIRST_SWING       = 0;

  // swing codes: 00 700 mV, 01 800 mV, 10 900 mV, 11 1000 mV
  localparam logic [1:0] SWING_700MV   = 2'h0;
  localparam logic [1:0] SWING_800MV   = 2'h1;
  localparam logic [1:0] SWING_900MV   = 2'h2;
  localparam logic [1:0] SWING_1000MV  = 2'h3;

  // bit counter marks
  localparam logic [3:0] BITS_BYTE     = 4'h8;
  localparam logic [3:0] BITS_ACKED    = 4'h9;

  // sampled bus events, one clock wide
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } coc_smb_ev_type;

endpackage

// ==== coc_smb_edge.sv ====
`timescale 1ns/1ps
module coc_smb_edge (
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // bus pins
  input  wire logic                    smb_clk_i,
  input  wire logic                    smb_dat_i,
  // events
  output coc_pkg::coc_smb_ev_type      ev_o
);

  logic scl_ff;
  logic sda_ff;
  logic scl_d_ff;
  logic sda_d_ff;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_ff   <= 1'b1;
      sda_ff   <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else if (ce_i) begin
      scl_ff   <= smb_clk_i;
      sda_ff   <= smb_dat_i;
      scl_d_ff <= scl_ff;
      sda_d_ff <= sda_ff;
    end
  end

  // start and stop are data edges while the clock stays high
  assign ev_o.scl_rise = scl_ff & ~scl_d_ff;
  assign ev_o.scl_fall = ~scl_ff & scl_d_ff;
  assign ev_o.start    = scl_ff & scl_d_ff & ~sda_ff & sda_d_ff;
  assign ev_o.stop     = scl_ff & scl_d_ff & sda_ff & ~sda_d_ff;
  assign ev_o.sda      = sda_ff;

endmodule

// ==== coc_regs_sva.sv ====
`timescale 1ns/1ps
module coc_regs_sva (
  // clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  // bus
  input wire logic       smb_clk_i,
  input wire logic       smb_dat_oe_n_o,
  // pairs and fields
  input wire logic [5:0] pair_clk_i,
  input wire logic [5:0] pair_true_o,
  input wire logic [5:0] pair_comp_o,
  input wire logic [5:0] out_on_o,
  input wire logic [1:0] upper_group_swing_o,
  input wire logic [1:0] middle_group_swing_o,
  input wire logic [1:0] first_output_swing_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire logic [5:0] swing = {upper_group_swing_o, middle_group_swing_o, first_output_swing_o};
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_vals: assert property ($fell(rst_i) |-> out_on_o == 6'h00 && swing == 6'h15
    && smb_dat_oe_n_o && (pair_true_o | pair_comp_o) == 6'h00) else $error("bad reset state");
  a_on_after_rst: assert property ($fell(rst_i) && ce_i |-> ##1 out_on_o == 6'h3f)
    else $error("enables not all on after reset");
  a_legs_apart: assert property ((pair_true_o & pair_comp_o) == 6'h00)
    else $error("both legs high");
  a_pair_follow: assert property (ce_i && $past(ce_i) && $stable(out_on_o)
    && $past(out_on_o) == $past(out_on_o, 2)
    |-> pair_true_o == (out_on_o & $past(pair_clk_i))
    && pair_comp_o == (out_on_o & ~$past(pair_clk_i))) else $error("pair legs wrong");
  a_off_quiet: assert property (((pair_true_o | pair_comp_o) & ~out_on_o
    & ~$past(out_on_o)) == 6'h00) else $error("disabled pair toggles");
  a_bus_steady: assert property (smb_clk_i && $past(smb_clk_i)
    |-> $stable(smb_dat_oe_n_o)) else $error("data moved while clock high");
  a_oe_release: assert property ($fell(smb_dat_oe_n_o) |-> ##[1:300] $rose(smb_dat_oe_n_o))
    else $error("data held low too long");
  a_swing_low: assert property ($changed(swing) |-> !smb_clk_i)
    else $error("swing changed outside a byte end");
  a_on_low: assert property (!$past(rst_i, 2) && $changed(out_on_o) |-> !smb_clk_i)
    else $error("enable changed outside a byte end");
endmodule

// ==== coc_host.sv ====
`timescale 1ns/1ps
module coc_host (
  // clock
  input  wire logic core_clk_i,
  // bus pins, data high means released
  output logic      smb_clk_o,
  output logic      smb_dat_o,
  input  wire logic smb_dat_i
);
  initial begin
    smb_clk_o = 1'b1;
    smb_dat_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // four phases of a bit, start or stop; data moves mid-low, sampled mid-high
  task automatic st(input logic d0, c1, d2, c3, output logic r);
    wt(4);
    smb_dat_o <= d0;
    wt(4);
    smb_clk_o <= c1;
    wt(4);
    smb_dat_o <= d2;
    r = smb_dat_i;
    wt(4);
    smb_clk_o <= c3;
  endtask
  // one byte msb first, then the ninth bit
  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      st(d[i], 1'b1, d[i], 1'b0, r);
      q[i] = r;
    end
    st(a, 1'b1, a, 1'b0, k);
  endtask
endmodule

// ==== tb_coc_regs.sv ====
`timescale 1ns/1ps
module tb_coc_regs;
  logic       core_clk_i = 1'b0;
  logic       rst_i      = 1'b1;
  logic       ce_i       = 1'b1;
  logic [5:0] pair_clk_i = 6'h00;
  wire        smb_clk_i;
  wire        host_dat;
  wire        smb_dat_o;
  wire        smb_dat_oe_n_o;
  wire  [5:0] pair_true_o;
  wire  [5:0] pair_comp_o;
  wire  [5:0] out_on_o;
  wire  [1:0] upper_group_swing_o;
  wire  [1:0] middle_group_swing_o;
  wire  [1:0] first_output_swing_o;
  // open-drain data wire with pull-up
  wire        smb_dat_i = host_dat & (smb_dat_oe_n_o | smb_dat_o);
  int         miscompares  = 0;
  int         total_checks = 0;
  int         seed         = 32'h59f2;
  int         j;
  logic [7:0] exp_r [1:9];
  logic [7:0] q;
  logic [7:0] d;
  logic       a;
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) pair_clk_i <= pair_clk_i + 6'h1b;
  coc_regs dut (.core_clk_i, .rst_i, .ce_i, .smb_clk_i, .smb_dat_i, .smb_dat_o,
    .smb_dat_oe_n_o, .pair_clk_i, .pair_true_o, .pair_comp_o, .out_on_o,
    .upper_group_swing_o, .middle_group_swing_o, .first_output_swing_o);
  coc_host host (.core_clk_i, .smb_clk_o(smb_clk_i), .smb_dat_o(host_dat), .smb_dat_i);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] msk(input int i);
    case (i)
      1: return coc_pkg::MSK_OE_LOW;
      3: return coc_pkg::MSK_OE_HIGH;
      5: return coc_pkg::MSK_AMP;
      9: return coc_pkg::MSK_OE_MID;
      default: return 8'h00;
    endcase
  endfunction
  task automatic dflt();
    exp_r = '{8'h48, 8'h00, 8'hc0, 8'h00, 8'h51, 8'h00, 8'h5a, 8'h0f, 8'h60};
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // send a byte, compare the device's ninth bit
  task automatic wb(input logic [7:0] v, input logic [7:0] ack);
    host.xb(v, 1'b1, q, a);
    chk({7'h00, a}, ack);
  endtask
  task automatic head(input logic [7:0] idx);
    host.st(1'b1, 1'b1, 1'b0, 1'b0, a);
    wb(coc_pkg::WR_ADDR, 8'h00);
    wb(idx, 8'h00);
  endtask
  task automatic rd_all();
    head(8'h01);
    host.st(1'b1, 1'b1, 1'b0, 1'b0, a);
    wb(coc_pkg::RD_ADDR, 8'h00);
    host.xb(8'hff, 1'b0, q, a);
    chk(q, 8'h0f);
    for (int i = 1; i <= 9; i++) begin
      host.xb(8'hff, i == 9, q, a);
      chk(q, exp_r[i]);
    end
    host.st(1'b0, 1'b1, 1'b1, 1'b1, a);
  endtask
  // cnt bytes stored from idx, one more sent past the count
  task automatic wr(input int idx, input int cnt, input logic [7:0] fix, input logic rnd);
    head(idx[7:0]);
    wb(cnt[7:0], 8'h00);
    for (int k = 0; k <= cnt; k++) begin
      d = rnd ? 8'($random(seed)) : fix;
      wb(d, 8'h00);
      if (k < cnt && msk(idx + k) != 8'h00) exp_r[idx + k] = d & msk(idx + k);
    end
    host.st(1'b0, 1'b1, 1'b1, 1'b1, a);
    chk({2'b00, out_on_o},
        {2'b00, exp_r[3][7:6], exp_r[9][6:5], exp_r[1][3], exp_r[1][6]});
    chk({upper_group_swing_o, middle_group_swing_o, 2'b00, first_output_swing_o},
        exp_r[5]);
  endtask
  task automatic bad_addr();
    d = 8'($random(seed));
    if (d[7:1] == 7'h69) d[7] = 1'b0;
    host.st(1'b1, 1'b1, 1'b0, 1'b0, a);
    wb(d, 8'h01);
    host.st(1'b0, 1'b1, 1'b1, 1'b1, a);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    dflt();
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd_all();
    for (int c = 0; c < 4; c++) wr(5, 1, {2'(c), 2'(c), 2'b11, 2'(c)}, 1'b0);
    wr(1, 9, 8'h00, 1'b1);
    wr(9, 0, 8'h00, 1'b1);
    for (int n = 0; n < 8; n++) begin
      bad_addr();
      j = 1 + ($unsigned($random(seed)) % 9);
      wr(j, $unsigned($random(seed)) % (10 - j), 8'h00, 1'b1);
      rd_all();
    end
    // clock enable low freezes the true legs of the pairs although their clocks run on
    ce_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    d = {2'b00, pair_true_o};
    repeat (5) @(posedge core_clk_i);
    chk({2'b00, pair_true_o}, d);
    ce_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    dflt();
    repeat (4) @(posedge core_clk_i);
    chk({2'b00, out_on_o}, 8'h3f);
    rd_all();
    results();
  end
  initial begin
    repeat (90000) @(posedge core_clk_i);
    miscompares++;
    results();
  end
endmodule
bind coc_regs coc_regs_sva chk_i (.core_clk_i, .rst_i, .ce_i, .smb_clk_i, .smb_dat_oe_n_o,
  .pair_clk_i, .pair_true_o, .pair_comp_o, .out_on_o, .upper_group_swing_o,
  .middle_group_swing_o, .first_output_swing_o);
